// ---- lcfh_pkg.sv ----
// Shared constants for the LED channel fault handler.
package lcfh_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_FAULT_LO = 8'h38;
   localparam logic [7:0] ADDR_FAULT_HI = 8'h39;
   localparam logic [7:0] ADDR_LATCH_LO = 8'h3a;
   localparam logic [7:0] ADDR_LATCH_HI = 8'h3b;
   localparam logic [7:0] ADDR_GND_SHORT = 8'h3c;
   localparam logic [7:0] ADDR_CH_ENABLE = 8'h3d;
   localparam logic [7:0] RESET_CH_ENABLE = 8'hff;
   // ----------------------------------------
   // Fault numbers, field positions and retest length
   // ----------------------------------------
   localparam int FAULT_TEMP_WARN = 3;
   localparam int FAULT_OVP = 8;
   localparam int FAULT_GND_SHORT = 11;
   localparam int RETEST_CYCLES = 4;
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {lcfh_run, lcfh_retest, lcfh_decide,
      lcfh_shutdown} lcfh_state_e;
endpackage : lcfh_pkg

// ---- lcfh_retest_if.sv ----
// Carrier between the fault sequencer and the short-retest timer.
`timescale 1ns/10ps
interface lcfh_retest_if;
   logic start;
   logic done;
   modport seq (output start, input done);
   modport tmr (input start, output done);
endinterface : lcfh_retest_if

// ---- lcfh_retest_timer.sv ----
// Settling timer for the ground-short retest.
`timescale 1ns/10ps
module lcfh_retest_timer #(
   parameter int CYCLES = lcfh_pkg::RETEST_CYCLES
) (
   // Clocking
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Sequencer link
   lcfh_retest_if.tmr rt
);
   logic [7:0] cnt_q;
   logic busy_q;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
      end else if (clk_en) begin
         if (rt.start) begin
            cnt_q <= 8'(CYCLES - 1);
            busy_q <= 1'b1;
         end else if (busy_q && cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end else begin
            busy_q <= 1'b0;
         end
      end
   end
   assign rt.done = busy_q && (cnt_q == 8'h00) && !rt.start;
endmodule : lcfh_retest_timer

// ---- lcfh_top.sv ----
// LED channel fault handler: regulation, short retest and fault status.
`timescale 1ns/10ps
module lcfh_top #(
   parameter int CHANNELS = 8
) (
   // Clocking
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Analog monitors
   input wire logic [CHANNELS-1:0] ch_regulated,
   input wire logic [CHANNELS-1:0] ch_gnd_short,
   input wire logic output_overvoltage_trip,
   input wire logic temp_near_thermal_shutdown_threshold,
   // Register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Channel control
   output logic [CHANNELS-1:0] boost_raise_req,
   output logic [CHANNELS-1:0] ch_active,
   output logic short_test_en,
   output logic boost_enable,
   output logic temp_warning,
   output logic led_derate,
   // Fault pin, open drain
   output logic fault_pin_o,
   output logic fault_pin_oe_n
);
   lcfh_retest_if rt ();
   lcfh_pkg::lcfh_state_e state_q;
   logic [CHANNELS-1:0] enable_q, removed_q, unreg_q, latch_q, short_q;
   logic [15:0] fault_q;
   logic flag_q, temp_q;
   logic [7:0] rdata_d;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] byte_of(input logic [15:0] w,
                                          input logic hi);
      byte_of = hi ? w[15:8] : w[7:0];
   endfunction : byte_of

   function automatic logic [15:0] widen(input logic [CHANNELS-1:0] v);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < CHANNELS && i < 16; i++) begin
         r[i] = v[i];
      end
      widen = r;
   endfunction : widen

   // ----------------------------------------
   // Channel regulation
   // ----------------------------------------
   assign ch_active = enable_q & ~removed_q;
   assign boost_raise_req = ch_active & ~ch_regulated &
      {CHANNELS{boost_enable}};

   // ----------------------------------------
   // Fault sequencer
   // ----------------------------------------
   assign rt.start = (state_q == lcfh_pkg::lcfh_run) &&
      output_overvoltage_trip;
   assign short_test_en = (state_q == lcfh_pkg::lcfh_retest);
   assign boost_enable = (state_q != lcfh_pkg::lcfh_shutdown);

   lcfh_retest_timer #(
      .CYCLES(lcfh_pkg::RETEST_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .rt(rt)
   );

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= lcfh_pkg::lcfh_run;
      end else if (clk_en) begin
         case (state_q)
            lcfh_pkg::lcfh_run: begin
               if (rt.start) begin
                  state_q <= lcfh_pkg::lcfh_retest;
               end
            end
            lcfh_pkg::lcfh_retest: begin
               if (rt.done) begin
                  state_q <= lcfh_pkg::lcfh_decide;
               end
            end
            lcfh_pkg::lcfh_decide: begin
               if (|(unreg_q & ch_gnd_short)) begin
                  state_q <= lcfh_pkg::lcfh_shutdown;
               end else begin
                  state_q <= lcfh_pkg::lcfh_run;
               end
            end
            lcfh_pkg::lcfh_shutdown: begin
               // No way out but reset: a shorted pin must not restart.
               state_q <= lcfh_pkg::lcfh_shutdown;
            end
            default: begin
               state_q <= lcfh_pkg::lcfh_run;
            end
         endcase
      end
   end

   // Unregulated set captured at the trip; retest judges only these.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         unreg_q <= '0;
      end else if (clk_en && rt.start) begin
         unreg_q <= ch_active & ~ch_regulated;
      end
   end

   // ----------------------------------------
   // Channel removal and status
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         removed_q <= '0;
         latch_q <= '0;
         short_q <= '0;
      end else if (clk_en && state_q == lcfh_pkg::lcfh_decide) begin
         if (|(unreg_q & ch_gnd_short)) begin
            short_q <= short_q | (unreg_q & ch_gnd_short);
         end else begin
            // Startup failures land here too: same open handling.
            removed_q <= removed_q | unreg_q;
            latch_q <= latch_q | unreg_q;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_q <= lcfh_pkg::RESET_CH_ENABLE[CHANNELS-1:0];
      end else if (clk_en && reg_wr &&
                   reg_addr == lcfh_pkg::ADDR_CH_ENABLE) begin
         enable_q <= reg_wdata[CHANNELS-1:0];
      end
   end

   // ----------------------------------------
   // Fault register and pin
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_q <= 16'h0000;
         flag_q <= 1'b0;
      end else if (clk_en) begin
         if (rt.start) begin
            fault_q[lcfh_pkg::FAULT_OVP] <= 1'b1;
            flag_q <= 1'b1;
         end else if (state_q == lcfh_pkg::lcfh_decide) begin
            if (|(unreg_q & ch_gnd_short)) begin
               fault_q[lcfh_pkg::FAULT_GND_SHORT] <= 1'b1;
            end else begin
               flag_q <= 1'b0;
            end
         end
         // Warning tracks the die level and leaves the pin alone.
         fault_q[lcfh_pkg::FAULT_TEMP_WARN] <= temp_q;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         temp_q <= 1'b0;
      end else if (clk_en) begin
         temp_q <= temp_near_thermal_shutdown_threshold;
      end
   end

   assign temp_warning = temp_q;
   assign led_derate = temp_q;
   assign fault_pin_o = 1'b0;
   assign fault_pin_oe_n = ~flag_q;

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   always_comb begin
      case (reg_addr)
         lcfh_pkg::ADDR_FAULT_LO: rdata_d = byte_of(fault_q, 1'b0);
         lcfh_pkg::ADDR_FAULT_HI: rdata_d = byte_of(fault_q, 1'b1);
         lcfh_pkg::ADDR_LATCH_LO:
            rdata_d = byte_of(widen(latch_q), 1'b0);
         lcfh_pkg::ADDR_LATCH_HI:
            rdata_d = byte_of(widen(latch_q), 1'b1);
         lcfh_pkg::ADDR_GND_SHORT:
            rdata_d = byte_of(widen(short_q), 1'b0);
         lcfh_pkg::ADDR_CH_ENABLE: rdata_d = byte_of(widen(enable_q), 1'b0);
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= rdata_d;
      end
   end
endmodule : lcfh_top

// ---- lcfh_props.sv ----
// Port checks for the LED channel fault handler.
`timescale 1ns/10ps
module lcfh_props #(
   parameter int CHANNELS = 8
) (
   // Inputs seen
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [CHANNELS-1:0] ch_regulated,
   input wire logic output_overvoltage_trip,
   input wire logic temp_near_thermal_shutdown_threshold,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   // Outputs seen
   input wire logic [7:0] reg_rdata,
   input wire logic [CHANNELS-1:0] boost_raise_req,
   input wire logic [CHANNELS-1:0] ch_active,
   input wire logic short_test_en,
   input wire logic boost_enable,
   input wire logic temp_warning,
   input wire logic fault_pin_o,
   input wire logic fault_pin_oe_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // The retest holds four cycles, then one decide cycle follows.
   sequence retest_s;
      short_test_en [*4] ##1 !short_test_en;
   endsequence
   a_raise_req: assert property (boost_raise_req == (ch_active &
      ~ch_regulated & {CHANNELS{boost_enable}})) else $error("raise");
   a_retest_len: assert property ($rose(short_test_en) |-> retest_s)
      else $error("retest length");
   a_retest_cause: assert property ($rose(short_test_en) |->
      $past(output_overvoltage_trip) && !fault_pin_oe_n) else $error("cause");
   a_no_restart: assert property (!boost_enable |=>
      !boost_enable && !short_test_en) else $error("restart");
   a_stop_timing: assert property ($fell(boost_enable) |->
      $past(short_test_en, 2)) else $error("stop timing");
   a_drop_open: assert property ((ch_active != $past(ch_active)) &&
      !$past(reg_wr) |-> boost_enable && $past(short_test_en, 2))
      else $error("drop");
   a_pin_clear: assert property ($rose(fault_pin_oe_n) |->
      boost_enable && $past(short_test_en, 2) && !fault_pin_o)
      else $error("pin clear");
   a_temp_copy: assert property ($past(clk_en) |-> temp_warning ==
      $past(temp_near_thermal_shutdown_threshold)) else $error("temp");
   a_freeze_hold: assert property (!clk_en |=> $stable(ch_active) &&
      $stable(temp_warning) && $stable(reg_rdata) && $stable(fault_pin_oe_n))
      else $error("freeze");
   a_temp_no_pin: assert property ($rose(temp_warning) |->
      $stable(fault_pin_oe_n)) else $error("temp pin");
   a_unmapped_rd: assert property ($past(reg_addr) == 8'h00 &&
      $past(clk_en) |->
      reg_rdata == 8'h00) else $error("unmapped");
endmodule : lcfh_props
bind lcfh_top lcfh_props #(.CHANNELS(CHANNELS)) u_lcfh_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
   .ch_regulated(ch_regulated),
   .output_overvoltage_trip(output_overvoltage_trip),
   .temp_near_thermal_shutdown_threshold(temp_near_thermal_shutdown_threshold),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
   .boost_raise_req(boost_raise_req), .ch_active(ch_active),
   .short_test_en(short_test_en), .boost_enable(boost_enable),
   .temp_warning(temp_warning), .fault_pin_o(fault_pin_o),
   .fault_pin_oe_n(fault_pin_oe_n));

// ---- lcfh_host_model.sv ----
// Bus host model that reads and writes the handler registers.
`timescale 1ns/10ps
module lcfh_host_model (
   // Clocking
   input wire logic sys_clk,
   // Register port
   output logic reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = ~d;
   endtask : wr
   // Parking on an unmapped address keeps stale data off the bus.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
      reg_addr = 8'h00;
   endtask : rd
endmodule : lcfh_host_model

// ---- tb.sv ----
// Self-checking bench for the LED channel fault handler.
`timescale 1ns/10ps
module tb;
   logic sys_clk, sys_rst, trip, temp, wr, ste, ben, tw, foe_n, fo, ld, ce;
   logic [7:0] regd, gnd, addr, wd, rdata, req, act, v;
   int err_total, checks;
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   lcfh_top u_lcfh_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clk_en(ce), .ch_regulated(regd), .ch_gnd_short(gnd),
      .output_overvoltage_trip(trip),
      .temp_near_thermal_shutdown_threshold(temp), .reg_wr(wr),
      .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
      .boost_raise_req(req), .ch_active(act), .short_test_en(ste),
      .boost_enable(ben), .temp_warning(tw), .led_derate(ld),
      .fault_pin_o(fo), .fault_pin_oe_n(foe_n));
   lcfh_host_model u_lcfh_host_model (.sys_clk(sys_clk), .reg_wr(wr),
      .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata));
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_lcfh_host_model.rd(a, v);
      chk($sformatf("reg %h", a), e, v);
   endtask : rd
   task automatic test_done;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // Pulse the trip, then wait for the decide cycle to land.
   // In shutdown the trip must be ignored, so the caller gives the expectation.
   task automatic trip_and_wait(input logic [7:0] e);
      @(negedge sys_clk) trip = 1'b1;
      @(negedge sys_clk) trip = 1'b0;
      chk("retest and pin", e, {ste, foe_n});
      for (int i = 0; i < 20 && ste !== 1'b0; i++) @(negedge sys_clk);
      if (ste !== 1'b0) begin
         err_total++;
         test_done;
      end
      @(negedge sys_clk);
   endtask : trip_and_wait
   task automatic t_reset;
      chk("boost and pin", 8'h06, {ben, foe_n, fo});
      rd(8'h3d, 8'hff);
      rd(8'h3a, 8'h00);
      rd(8'h38, 8'h00);
   endtask : t_reset
   task automatic t_disable;
      regd = 8'hfe;
      @(negedge sys_clk) chk("raise", 8'h01, req);
      u_lcfh_host_model.wr(8'h3d, 8'hfe);
      chk("raise off", 8'h00, req);
      u_lcfh_host_model.wr(8'h3d, 8'hff);
      regd = 8'hfd;
   endtask : t_disable
   task automatic t_open;
      trip_and_wait(8'h02);
      chk("active", 8'hfd, act);
      chk("pin and raise", 8'h01, {req[6:0], foe_n});
      rd(8'h3a, 8'h02);
      rd(8'h3b, 8'h00);
      rd(8'h39, 8'h01);
   endtask : t_open
   task automatic t_temp;
      @(negedge sys_clk) temp = 1'b1;
      @(negedge sys_clk) chk("warn", 8'h07, {tw, ld, foe_n});
      rd(8'h38, 8'h08);
      temp = 1'b0;
   endtask : t_temp
   // With the enable low, a write and a warning must both be held off.
   task automatic t_freeze;
      @(negedge sys_clk);
      ce = 1'b0;
      temp = 1'b1;
      u_lcfh_host_model.wr(8'h3d, 8'h00);
      chk("frozen", 8'hfd, act);
      chk("frozen warn", 8'h00, {7'h00, tw});
      ce = 1'b1;
      temp = 1'b0;
      @(negedge sys_clk) chk("thawed", 8'hfd, act);
   endtask : t_freeze
   task automatic t_short;
      regd = 8'hf5;
      gnd = 8'h08;
      trip_and_wait(8'h02);
      chk("boost", 8'h00, {7'h00, ben});
      rd(8'h39, 8'h09);
      rd(8'h3c, 8'h08);
      trip_and_wait(8'h00);
      chk("no restart", 8'h00, {7'h00, ben});
   endtask : t_short
   initial begin
      err_total = 0;
      checks = 0;
      sys_rst = 1'b1;
      ce = 1'b1;
      trip = 1'b0;
      temp = 1'b0;
      regd = 8'hff;
      gnd = 8'h00;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_reset;
      t_disable;
      t_open;
      t_temp;
      t_freeze;
      t_short;
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_reset;
      test_done;
   end
endmodule : tb
